// ### include/clamp_consts.svh
/*
  register offsets, field positions, reset values and clamp target codes
  for the clamp, gain and offset control block.
  assumes it is included by bare name after the include path is set.
*/
`ifndef CLAMP_CONSTS_SVH
`define CLAMP_CONSTS_SVH

`define OFS_START_DELAY   8'h05
`define OFS_LENGTH        8'h06
`define OFS_RED_FS        8'h08
`define OFS_GREEN_FS      8'h09
`define OFS_BLUE_FS       8'h0a
`define OFS_RED_SHIFT     8'h0b
`define OFS_GREEN_SHIFT   8'h0c
`define OFS_BLUE_SHIFT    8'h0d
`define OFS_CTL_A         8'h0f
`define OFS_CTL_B         8'h10
`define OFS_STATUS        8'h12

`define BIT_EXT_CLAMP     7
`define BIT_PIN_POL       6
`define BIT_BW_HI         1
`define BIT_BW_LO         0
`define BIT_RED_MID       1
`define BIT_BLUE_MID      2

`define RST_START_DELAY   8'h08
`define RST_LENGTH        8'h14
`define RST_FULL_SCALE    8'h80
`define RST_SHIFT         7'h40
`define RST_CTL_A         8'h40
`define RST_CTL_B         8'h00

`define CODE_GROUND       8'h00
`define CODE_MIDSCALE     8'h80
`define SHIFT_CENTRE      8'h40
`define SHIFT_SPAN        8'h3f
`define SCALE_BASE        10'h0ff
`define TRIM_MAX          8'h7f
`define TRIM_MIN          8'h81

`endif

// ### include/clamp_pkg.sv
/*
  types shared by the clamp control top and its timing generator.
  assumes nothing beyond a synthesizable sv toolchain.
*/
package clamp_pkg;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_WAIT  = 2'b01,
    ST_CLAMP = 2'b10
  } timer_state_e;

  typedef struct packed {
    timer_state_e state;
    logic [7:0]   cnt;
    logic         sync_q;
    logic         clamp;
  } timer_s;

  typedef struct packed {
    logic [7:0]            start_delay;
    logic [7:0]            length;
    logic [2:0][7:0]       full_scale;
    logic [2:0][6:0]       level_shift;
    logic [7:0]            ctl_a;
    logic [7:0]            ctl_b;
    logic [7:0]            rdata;
    logic [2:0][7:0]       trim;
    logic [2:0][17:0]      drive;
  } ctrl_s;

endpackage

// ### include/clamp_timing_if.sv
/*
  carries clamp timing settings down to the timing generator and the
  clamp strobe back up.
  assumes both ends sit on the same pixel clock.
*/
`timescale 1ns/1ns
`default_nettype none

interface clamp_timing_if;
  logic [7:0] start_delay;
  logic [7:0] length;
  logic       line_sync;
  logic       use_pin;
  logic       pin_level;
  logic       pin_active_high;
  logic       clamp;

  modport ctrl  (output start_delay, length, line_sync, use_pin,
                 pin_level, pin_active_high, input clamp);
  modport timer (input start_delay, length, line_sync, use_pin,
                 pin_level, pin_active_high, output clamp);
endinterface

`default_nettype wire

// ### core/clamp_timer.sv
/*
  clamp timing generator: internal placement/duration counter or the
  external clamp pin with selectable polarity.
  assumes mclk is the pixel clock and all inputs are synchronous to it.
*/
`timescale 1ns/1ns
`default_nettype none

module clamp_timer (
  input wire logic        mclk,
  input wire logic        nrst,
  clamp_timing_if.timer   tif
);

  clamp_pkg::timer_s r;
  clamp_pkg::timer_s next_r;
  logic              trailing;

  // line sync is taken as active high, so its trailing edge is a fall
  assign trailing = r.sync_q & ~tif.line_sync;

  always_comb begin
    next_r        = r;
    next_r.sync_q = tif.line_sync;
    case (r.state)
      clamp_pkg::ST_WAIT: begin
        next_r.cnt = r.cnt + 8'h01;
        if (r.cnt + 8'h01 == tif.start_delay) begin // RULE1
          next_r.state = clamp_pkg::ST_CLAMP;
          next_r.cnt   = 8'h00;
        end
      end
      clamp_pkg::ST_CLAMP: begin
        next_r.cnt = r.cnt + 8'h01;
        if (r.cnt + 8'h01 == tif.length) begin // RULE2
          next_r.state = clamp_pkg::ST_IDLE;
          next_r.cnt   = 8'h00;
        end
      end
      clamp_pkg::ST_IDLE: begin
        next_r.cnt = 8'h00;
      end
      default: begin
        next_r.state = clamp_pkg::ST_IDLE;
        next_r.cnt   = 8'h00;
      end
    endcase
    // a new line always wins over an interval still in progress
    if (trailing) begin // RULE16
      next_r.cnt = 8'h00;
      if (tif.start_delay == 8'h00) begin // RULE1
        next_r.state = (tif.length == 8'h00) ? clamp_pkg::ST_IDLE
                                             : clamp_pkg::ST_CLAMP;
      end else begin
        next_r.state = clamp_pkg::ST_WAIT;
      end
    end
    // a zero length means no internal clamp at all
    if (next_r.state == clamp_pkg::ST_CLAMP && tif.length == 8'h00) begin
      next_r.state = clamp_pkg::ST_IDLE;
    end
    if (tif.use_pin) begin // RULE3
      next_r.clamp = (tif.pin_level == tif.pin_active_high); // RULE4
    end else begin
      next_r.clamp = (next_r.state == clamp_pkg::ST_CLAMP); // RULE2
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      r <= '{state: clamp_pkg::ST_IDLE, cnt: 8'h00,
             sync_q: 1'b0, clamp: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  assign tif.clamp = r.clamp;

endmodule // clamp_timer

`default_nettype wire

// ### core/clamp_gain_offset_control.sv
/*
  clamp, gain and offset control for a three channel video digitizer:
  decoded register port, clamp timing, digital clamp trim loop, gain and
  scaled offset drive for the analog front end, bandwidth select.
  assumes mclk is the pixel clock made by the line-sync locked loop,
  that the serial port outside decodes accesses into the register port,
  and that adc codes arrive synchronous to mclk.
*/
// What this block does
// RULE1: after each sync trailing edge, wait placement pixels, then clamp.
// RULE2: internal clamp lasts duration pixels; timing registers are 8-bit.
// RULE3: source bit set selects external clamp pin, pulsed in back porch.
// RULE4: external clamp pin active level set by control bit 6 at 0x0f.
// RULE5: ground clamped channel trims offset so black converts to code 0x00.
// RULE6: midscale clamped channel trims so its reference converts to 0x80.
// RULE7: red and blue midscale select bits at 0x10 bits 1 and 2.
// RULE8: three 8-bit full-scale registers 0x08..0x0a; larger widens range.
// RULE9: three 7-bit offset registers 0x0b..0x0d, each shifting one channel.
// RULE10: offset spans plus or minus 63 steps about the centre value.
// RULE11: offset step scales with full-scale range, doubling from min to max.
// RULE12: four selectable analog bandwidth settings, narrowest to widest.
// RULE13: software should start at placement 8 and duration 20 pixels.
// RULE14: without line sync use external clock, external clamp, single port. Only the clamp pin select exists here.
// RULE15: placement and duration count pixel clocks from the sync-locked loop.
// RULE16: each line sync trailing edge restarts placement, one clamp per line.
`timescale 1ns/1ns
`default_nettype none
`include "clamp_consts.svh"

module clamp_gain_offset_control (
  input  wire logic                mclk,
  input  wire logic                nrst,
  input  wire logic                line_sync,
  input  wire logic                clamp_pin,
  input  wire logic [7:0]          reg_addr,
  input  wire logic                reg_wr,
  input  wire logic [7:0]          reg_wdata,
  output logic      [7:0]          reg_rdata,
  input  wire logic [7:0]          red_code,
  input  wire logic [7:0]          green_code,
  input  wire logic [7:0]          blue_code,
  output logic                     clamp,
  output logic      [7:0]          red_gain,
  output logic      [7:0]          green_gain,
  output logic      [7:0]          blue_gain,
  output logic      [17:0]         red_offset_drive,
  output logic      [17:0]         green_offset_drive,
  output logic      [17:0]         blue_offset_drive,
  output logic      [7:0]          red_trim,
  output logic      [7:0]          green_trim,
  output logic      [7:0]          blue_trim,
  output logic      [1:0]          bandwidth_sel
);

  clamp_pkg::ctrl_s  r;
  clamp_pkg::ctrl_s  next_r;
  clamp_timing_if    tif ();

  logic [2:0][7:0]   code;
  logic [2:0][7:0]   target;
  logic [2:0][17:0]  drive;
  logic [2:0]        mid_sel;

  assign code = {blue_code, green_code, red_code};

  // green has no midscale option; it always clamps to ground
  assign mid_sel = {r.ctl_b[`BIT_BLUE_MID], 1'b0,
                    r.ctl_b[`BIT_RED_MID]}; // RULE7

  // clamp timing runs on mclk, which is the loop's pixel clock
  assign tif.start_delay     = r.start_delay; // RULE15
  assign tif.length          = r.length; // RULE15
  assign tif.line_sync       = line_sync;
  assign tif.use_pin         = r.ctl_a[`BIT_EXT_CLAMP]; // RULE3
  assign tif.pin_level       = clamp_pin;
  assign tif.pin_active_high = r.ctl_a[`BIT_PIN_POL]; // RULE4

  clamp_timer u_timer (
    .mclk (mclk),
    .nrst (nrst),
    .tif  (tif)
  );

  genvar ch;
  generate
    for (ch = 0; ch < 3; ch++) begin : g_chan
      logic signed [7:0] steps;
      logic signed [9:0] scale;
      logic signed [17:0] product;

      assign target[ch] = mid_sel[ch] ? `CODE_MIDSCALE
                                      : `CODE_GROUND; // RULE5 RULE6

      // register value 0x40 is centre; code 0x00 would reach -64, so it
      // saturates to -63 to keep the span symmetric
      always_comb begin
        steps = $signed({1'b0, r.level_shift[ch]}) - $signed(`SHIFT_CENTRE);
        if (steps < -$signed(`SHIFT_SPAN)) begin
          steps = -$signed(`SHIFT_SPAN); // RULE10
        end
      end

      // step size follows the full-scale range: 255 at gain 0, 510 at
      // gain 255, so the range and the step double together
      assign scale   = $signed(`SCALE_BASE)
                     + $signed({2'b00, r.full_scale[ch]}); // RULE11
      assign product = steps * scale; // RULE11
      assign drive[ch] = product;
    end
  endgenerate

  always_comb begin
    next_r = r;

    if (reg_wr) begin
      case (reg_addr)
        `OFS_START_DELAY: next_r.start_delay    = reg_wdata; // RULE1
        `OFS_LENGTH:      next_r.length         = reg_wdata; // RULE2
        `OFS_RED_FS:      next_r.full_scale[0]  = reg_wdata; // RULE8
        `OFS_GREEN_FS:    next_r.full_scale[1]  = reg_wdata; // RULE8
        `OFS_BLUE_FS:     next_r.full_scale[2]  = reg_wdata; // RULE8
        `OFS_RED_SHIFT:   next_r.level_shift[0] = reg_wdata[6:0]; // RULE9
        `OFS_GREEN_SHIFT: next_r.level_shift[1] = reg_wdata[6:0]; // RULE9
        `OFS_BLUE_SHIFT:  next_r.level_shift[2] = reg_wdata[6:0]; // RULE9
        `OFS_CTL_A:       next_r.ctl_a          = reg_wdata; // RULE4
        `OFS_CTL_B:       next_r.ctl_b          = reg_wdata; // RULE7
        default: begin
        end
      endcase
    end

    // read data is the addressed register one cycle later
    case (reg_addr)
      `OFS_START_DELAY: next_r.rdata = r.start_delay;
      `OFS_LENGTH:      next_r.rdata = r.length;
      `OFS_RED_FS:      next_r.rdata = r.full_scale[0];
      `OFS_GREEN_FS:    next_r.rdata = r.full_scale[1];
      `OFS_BLUE_FS:     next_r.rdata = r.full_scale[2];
      `OFS_RED_SHIFT:   next_r.rdata = {1'b0, r.level_shift[0]};
      `OFS_GREEN_SHIFT: next_r.rdata = {1'b0, r.level_shift[1]};
      `OFS_BLUE_SHIFT:  next_r.rdata = {1'b0, r.level_shift[2]};
      `OFS_CTL_A:       next_r.rdata = r.ctl_a;
      `OFS_CTL_B:       next_r.rdata = r.ctl_b;
      `OFS_STATUS:      next_r.rdata = {6'h00, line_sync, tif.clamp};
      default:          next_r.rdata = 8'h00;
    endcase

    // one trim step per pixel while clamping: slow, but it cannot ring
    // and a large input offset still settles within a few lines
    for (int i = 0; i < 3; i++) begin
      if (tif.clamp) begin
        if (code[i] > target[i] && r.trim[i] != `TRIM_MIN) begin
          next_r.trim[i] = r.trim[i] - 8'h01; // RULE5 RULE6
        end else if (code[i] < target[i] && r.trim[i] != `TRIM_MAX) begin
          next_r.trim[i] = r.trim[i] + 8'h01; // RULE5 RULE6
        end
      end
      next_r.drive[i] = drive[i]; // RULE9 RULE11
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      r.start_delay <= `RST_START_DELAY;
      r.length      <= `RST_LENGTH;
      r.full_scale  <= {3{`RST_FULL_SCALE}};
      r.level_shift <= {3{`RST_SHIFT}};
      r.ctl_a       <= `RST_CTL_A;
      r.ctl_b       <= `RST_CTL_B;
      r.rdata       <= 8'h00;
      r.trim        <= {3{8'h00}};
      r.drive       <= {3{18'h00000}};
    end else begin
      r <= next_r;
    end
  end

  assign reg_rdata          = r.rdata;
  assign clamp              = tif.clamp;
  assign red_gain           = r.full_scale[0]; // RULE8
  assign green_gain         = r.full_scale[1]; // RULE8
  assign blue_gain          = r.full_scale[2]; // RULE8
  assign red_offset_drive   = r.drive[0];
  assign green_offset_drive = r.drive[1];
  assign blue_offset_drive  = r.drive[2];
  assign red_trim           = r.trim[0];
  assign green_trim         = r.trim[1];
  assign blue_trim          = r.trim[2];
  // 00 narrowest through 11 widest
  assign bandwidth_sel      = r.ctl_a[`BIT_BW_HI:`BIT_BW_LO]; // RULE12

endmodule // clamp_gain_offset_control

`default_nettype wire

// ### verif/clamp_chk.sv
/*
  concurrent checks on the clamp, gain and offset control top ports.
  assumes registers change only through the decoded register port.
*/
`timescale 1ns/1ns
`default_nettype none
`include "clamp_consts.svh"

module clamp_chk (
  input wire logic        mclk,
  input wire logic        nrst,
  input wire logic        line_sync,
  input wire logic        clamp_pin,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic [7:0]  reg_wdata,
  input wire logic [7:0]  red_code,
  input wire logic [7:0]  green_code,
  input wire logic        clamp,
  input wire logic [7:0]  green_gain,
  input wire logic [17:0] red_offset_drive,
  input wire logic [7:0]  red_trim,
  input wire logic [7:0]  green_trim,
  input wire logic [7:0]  blue_trim,
  input wire logic [1:0]  bandwidth_sel
);
  logic        [7:0]  d, l, ca, cb, rg;
  logic        [6:0]  rs;
  logic               s_q, ok;
  logic        [9:0]  age;
  logic signed [17:0] st, fs, exp_dr;
  wire                fall = s_q & ~line_sync;
  wire                tw = reg_wr && (reg_addr == `OFS_START_DELAY ||
                         reg_addr == `OFS_LENGTH || reg_addr == `OFS_CTL_A);

  assign st = (rs == 7'h00) ? -18'sh3f : $signed({11'h000, rs}) - 18'sh40;
  assign fs = $signed({10'h000, rg}) + 18'sh0ff;
  assign exp_dr = st * fs;

  // sync edge tracking runs through reset so no false edge at release
  always_ff @(posedge mclk) begin
    s_q <= line_sync;
    age <= fall ? 10'h000 : (age == 10'h3ff ? age : age + 10'h001);
    if (!nrst) begin
      d <= `RST_START_DELAY;
      l <= `RST_LENGTH;
      ca <= `RST_CTL_A;
      cb <= `RST_CTL_B;
      rg <= `RST_FULL_SCALE;
      rs <= `RST_SHIFT;
      ok <= 1'b0;
    end else begin
      if (fall) ok <= 1'b1;
      // a timing write mid-line leaves that line undefined
      if (tw) ok <= 1'b0;
      if (reg_wr && reg_addr == `OFS_START_DELAY) d <= reg_wdata;
      if (reg_wr && reg_addr == `OFS_LENGTH) l <= reg_wdata;
      if (reg_wr && reg_addr == `OFS_CTL_A) ca <= reg_wdata;
      if (reg_wr && reg_addr == `OFS_CTL_B) cb <= reg_wdata;
      if (reg_wr && reg_addr == `OFS_RED_FS) rg <= reg_wdata;
      if (reg_wr && reg_addr == `OFS_RED_SHIFT) rs <= reg_wdata[6:0];
    end
  end

  a_internal_clamp: assert property (
    @(posedge mclk) disable iff (!nrst) ok && !ca[7] |->
    clamp == (age >= {2'h0, d} && age < {2'h0, d} + {2'h0, l}))
    else $error("internal clamp timing wrong");
  a_external_clamp: assert property (
    @(posedge mclk) disable iff (!nrst) $past(ca[7]) |->
    clamp == ($past(clamp_pin) == $past(ca[6])))
    else $error("external clamp does not follow pin");
  a_gain_write: assert property (
    @(posedge mclk) disable iff (!nrst) reg_wr && reg_addr == `OFS_GREEN_FS
    |=> green_gain == $past(reg_wdata))
    else $error("green gain not updated");
  a_bandwidth_write: assert property (
    @(posedge mclk) disable iff (!nrst) reg_wr && reg_addr == `OFS_CTL_A
    |=> bandwidth_sel == $past(reg_wdata[1:0]))
    else $error("bandwidth select not updated");
  a_offset_drive: assert property (
    @(posedge mclk) disable iff (!nrst)
    exp_dr == $past(exp_dr) && exp_dr == $past(exp_dr, 2) |->
    red_offset_drive == exp_dr)
    else $error("red offset drive wrong");
  a_trim_idle: assert property (
    @(posedge mclk) disable iff (!nrst)
    !clamp |=> $stable({red_trim, green_trim, blue_trim}))
    else $error("trim moved outside clamp");
  a_ground_trim: assert property (
    @(posedge mclk) disable iff (!nrst)
    clamp && green_code > 8'h00 && green_trim != 8'h81 |=>
    green_trim == $past(green_trim) - 8'h01)
    else $error("green trim did not step down");
  a_midscale_trim: assert property (
    @(posedge mclk) disable iff (!nrst)
    clamp && cb[1] && red_code < 8'h80 && red_trim != 8'h7f |=>
    red_trim == $past(red_trim) + 8'h01)
    else $error("red trim did not step up");
endmodule // clamp_chk

bind clamp_gain_offset_control clamp_chk chk_u (.mclk, .nrst, .line_sync,
  .clamp_pin, .reg_addr, .reg_wr, .reg_wdata, .red_code, .green_code,
  .clamp, .green_gain, .red_offset_drive, .red_trim, .green_trim,
  .blue_trim, .bandwidth_sel);

`default_nettype wire

// ### verif/video_source.sv
/*
  graphics source model: 64 pixel lines, sync, back porch clamp pulse.
  assumes it is clocked by the pixel clock and drives off falling edges.
*/
`timescale 1ns/1ns
`default_nettype none

module video_source (
  input  wire logic       mclk,
  input  wire logic       pin_high,
  output logic            line_sync,
  output logic            clamp_pin,
  output logic      [7:0] red_code,
  output logic      [7:0] green_code,
  output logic      [7:0] blue_code
);
  logic [5:0] pos = 6'h00;
  logic [7:0] vid = 8'h00;
  wire        porch = pos < 6'h28;

  always @(negedge mclk) begin
    pos <= pos + 6'h01;
    vid <= 8'($urandom);
  end
  assign line_sync = pos < 6'h06;
  assign clamp_pin = (pos >= 6'h0a && pos < 6'h14) == pin_high;
  // black sits below midscale so both trim directions get exercised
  assign red_code = porch ? 8'h10 : vid;
  assign green_code = porch ? 8'h10 : ~vid;
  assign blue_code = porch ? 8'h10 : vid;
endmodule // video_source

`default_nettype wire

// ### verif/clamp_gain_offset_control_tb_top.sv
/*
  self-checking bench for the clamp, gain and offset control block.
  assumes the checker is bound in and the source model drives video.
*/
`timescale 1ns/1ns
`default_nettype none

module clamp_gain_offset_control_tb_top;
  logic        mclk, nrst, reg_wr, clamp, pin_high, line_sync, clamp_pin;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, red_code, green_code;
  logic [7:0]  blue_code, red_gain, green_gain, blue_gain;
  logic [7:0]  red_trim, green_trim, blue_trim, v, w;
  logic [17:0] red_offset_drive, green_offset_drive, blue_offset_drive;
  logic [1:0]  bandwidth_sel;
  int          fail_count = 0, tests_run = 0, rise, len;
  logic [7:0]  ofs [10] = '{8'h05, 8'h06, 8'h08, 8'h09, 8'h0a, 8'h0b,
                            8'h0c, 8'h0d, 8'h0f, 8'h10};
  logic [7:0]  rst [10] = '{8'h08, 8'h14, 8'h80, 8'h80, 8'h80, 8'h40,
                            8'h40, 8'h40, 8'h40, 8'h00};
  logic [15:0] dl [3] = '{16'h0001, 16'h0814, 16'h0000};

  clamp_gain_offset_control dut_u (.mclk, .nrst, .line_sync, .clamp_pin,
    .reg_addr, .reg_wr, .reg_wdata, .reg_rdata, .red_code, .green_code,
    .blue_code, .clamp, .red_gain, .green_gain, .blue_gain,
    .red_offset_drive, .green_offset_drive, .blue_offset_drive,
    .red_trim, .green_trim, .blue_trim, .bandwidth_sel);
  video_source src_u (.mclk, .pin_high, .line_sync, .clamp_pin, .red_code,
    .green_code, .blue_code);

  function automatic logic [17:0] exp_drive(input logic [7:0] s, g);
    int st;
    st = (s[6:0] == 7'h00) ? -63 : int'(s[6:0]) - 64;
    return 18'(st * (255 + int'(g)));
  endfunction

  task automatic chk(input string what, input logic [17:0] exp, got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, e);
    @(negedge mclk);
    reg_addr = a;
    @(negedge mclk);
    chk("reg_rdata", 18'(e), 18'(reg_rdata));
  endtask

  // clamp onset and width in pixels after the sync trailing edge
  task automatic line();
    int n;
    n = 0;
    rise = 0;
    len = 0;
    @(posedge mclk iff line_sync);
    @(posedge mclk iff !line_sync);
    repeat (50) begin
      @(negedge mclk);
      if (clamp === 1'b1) begin
        if (len == 0) rise = n;
        len++;
      end
      n++;
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  initial begin
    #(40 * 20000);
    fail_count++;
    end_of_test();
  end

  initial begin
    nrst = 1'b0;
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    pin_high = 1'b1;
    void'($urandom(32'h956b32fe));
    repeat (2) @(negedge mclk);
    nrst = 1'b1;
    foreach (ofs[i]) rd(ofs[i], rst[i]);
    foreach (ofs[i]) begin
      v = 8'($urandom);
      wr(ofs[i], v);
      rd(ofs[i], (i >= 5 && i <= 7) ? v & 8'h7f : v);
    end
    wr(8'h07, 8'($urandom));
    rd(8'h07, 8'h00);
    wr(8'h10, 8'h00);
    for (int b = 0; b < 4; b++) begin
      wr(8'h0f, 8'h40 | 8'(b));
      chk("bandwidth_sel", 18'(b), 18'(bandwidth_sel));
    end
    for (int i = 0; i < 6; i++) begin
      v = (i < 3) ? dl[i][15:8] : 8'($urandom_range(15));
      w = (i < 3) ? dl[i][7:0] : 8'($urandom_range(15, 1));
      wr(8'h05, v);
      wr(8'h06, w);
      line();
      chk("clamp_len", 18'(w), 18'(len));
      if (w > 0) chk("clamp_rise", 18'(v), 18'(rise));
    end
    for (int p = 0; p < 2; p++) begin
      pin_high = p[0];
      wr(8'h0f, {1'b1, p[0], 6'h00});
      line();
      chk("ext_len", 18'h0000a, 18'(len));
      chk("ext_rise", 18'h00004, 18'(rise));
    end
    for (int i = 0; i < 4; i++) begin
      v = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
      w = (i == 2) ? 8'h40 : ~v;
      wr(8'h0b, w);
      wr(8'h0c, v);
      wr(8'h0d, w);
      wr(8'h08, v);
      wr(8'h09, ~v);
      wr(8'h0a, v);
      repeat (2) @(negedge mclk);
      chk("red_gain", 18'(v), 18'(red_gain));
      chk("green_gain", 18'(v ^ 8'hff), 18'(green_gain));
      chk("blue_gain", 18'(v), 18'(blue_gain));
      chk("red_offset_drive", exp_drive(w, v),
          red_offset_drive);
      chk("green_offset_drive", exp_drive(v, ~v), green_offset_drive);
      chk("blue_offset_drive", exp_drive(w, v), blue_offset_drive);
    end
    wr(8'h0f, 8'h40);
    wr(8'h10, 8'h02);
    wr(8'h05, 8'h08);
    wr(8'h06, 8'h14);
    // 13 lines of 20 clamp pixels saturate a trim from any start
    repeat (13) line();
    chk("red_trim", 18'h0007f, 18'(red_trim));
    chk("green_trim", 18'h00081, 18'(green_trim));
    chk("blue_trim", 18'h00081, 18'(blue_trim));
    end_of_test();
  end
endmodule // clamp_gain_offset_control_tb_top

`default_nettype wire
